// >>> src/bcss_reg_bank.v
`include "bcss_regs.vh"

module bcss_reg_bank
(
   input  wire                                       clk_sys,
   input  wire                                       rst,
   input  wire                                       clkEn,
   input  wire                                       defaultLoad,
   input  wire                                       wrEn,
   input  wire [`BCSS_ADDR_BITS-1:0]                 wrAddr,
   input  wire [`BCSS_DATA_BITS-1:0]                 wrData,
   input  wire [`BCSS_ADDR_BITS-1:0]                 rdAddr,
   output wire [`BCSS_DATA_BITS-1:0]                 rdData,
   output wire [`BCSS_REG_COUNT*`BCSS_DATA_BITS-1:0] cfgRegs
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   reg [`BCSS_DATA_BITS-1:0] regs_ff [0:`BCSS_REG_COUNT-1];
   integer                   i;
   genvar                    g;

   // Address lies inside the implemented bank
   function isMapped;
      input [`BCSS_ADDR_BITS-1:0] addr;
      begin
         isMapped = (addr < `BCSS_REG_COUNT);
      end
   endfunction

   // Write port, defaults on either reset
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (i = 0; i < `BCSS_REG_COUNT; i = i + 1)
            regs_ff[i] <= `BCSS_REG_DEFAULT;
      end
      else if (clkEn)
      begin
         if (defaultLoad)
         begin
            for (i = 0; i < `BCSS_REG_COUNT; i = i + 1)
               regs_ff[i] <= `BCSS_REG_DEFAULT;
         end
         else if (wrEn && isMapped(wrAddr))
            regs_ff[wrAddr[`BCSS_IDX_BITS-1:0]] <= wrData;
      end
   end

   // Read select, unmapped reads as zero
   assign rdData = isMapped(rdAddr) ? regs_ff[rdAddr[`BCSS_IDX_BITS-1:0]]
                                    : {`BCSS_DATA_BITS{1'b0}};

   // Flattened view for the user side
   generate
      for (g = 0; g < `BCSS_REG_COUNT; g = g + 1)
      begin : gFlat
         assign cfgRegs[g*`BCSS_DATA_BITS +: `BCSS_DATA_BITS] = regs_ff[g];
      end
   endgenerate

endmodule // bcss_reg_bank

// >>> src/bcss_regs.vh
`ifndef BCSS_REGS_VH
`define BCSS_REGS_VH

// ------------------------------------------------------------------
// Transaction layout
// ------------------------------------------------------------------
`define BCSS_ADDR_BITS      12
`define BCSS_DATA_BITS      32
`define BCSS_FRAME_BITS     6'd44
`define BCSS_ADDR_LAST      6'd12
`define BCSS_OUT_LAST       5'd31

// ------------------------------------------------------------------
// Register bank
// ------------------------------------------------------------------
`define BCSS_REG_COUNT      16
`define BCSS_IDX_BITS       4
`define BCSS_REG_DEFAULT    32'h00000000

// ------------------------------------------------------------------
// Link timing
// ------------------------------------------------------------------
`define BCSS_LINK_RATE_KHZ  500
`define BCSS_SYS_RATE_KHZ   25000
`define BCSS_SYS_PER_BIT    (`BCSS_SYS_RATE_KHZ / `BCSS_LINK_RATE_KHZ)

`endif

// >>> src/bcss_serial_slave.v
// Notes on behaviour
// - Configuration reset reloads all register defaults.
// - Load strobe ends write or requests read.
// - Frame is 12-bit address, 32-bit data.
// - Write captures address and data at load.
// - Read latches address at load, selects register.
// - Read data leaves least significant first.
// - Serial output sits low when not reading.
// - Reset request output held inactive high.
`include "bcss_regs.vh"

module bcss_serial_slave
(
   input  wire                                       clk_sys,
   input  wire                                       rst,
   input  wire                                       clkEn,
   input  wire                                       cfgSerialClock,
   input  wire                                       cfgDefaultResetN,
   input  wire                                       cfgLoadStrobe,
   input  wire                                       cfgWriteNotRead,
   input  wire                                       cfgSerialIn,
   output wire                                       cfgSerialOut,
   output wire                                       softResetRequestN,
   output wire                                       cfgWritePulse,
   output wire [`BCSS_REG_COUNT*`BCSS_DATA_BITS-1:0] cfgRegs
);

   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam ST_SHIFT   = 1'b0;
   localparam ST_READOUT = 1'b1;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   reg  [4:0]                 syncA_ff;
   reg  [4:0]                 syncB_ff;
   reg                        sclkDly_ff;
   reg                        loadDly_ff;
   reg                        state_ff;
   reg                        nxt_state;
   reg  [5:0]                 bitCnt_ff;
   reg  [5:0]                 nxt_bitCnt;
   reg  [`BCSS_ADDR_BITS-1:0] addrSh_ff;
   reg  [`BCSS_ADDR_BITS-1:0] nxt_addrSh;
   reg  [`BCSS_DATA_BITS-1:0] dataSh_ff;
   reg  [`BCSS_DATA_BITS-1:0] nxt_dataSh;
   reg  [`BCSS_ADDR_BITS-1:0] rdAddr_ff;
   reg  [`BCSS_ADDR_BITS-1:0] nxt_rdAddr;
   reg  [`BCSS_DATA_BITS-1:0] outSh_ff;
   reg  [`BCSS_DATA_BITS-1:0] nxt_outSh;
   reg  [4:0]                 outCnt_ff;
   reg  [4:0]                 nxt_outCnt;
   reg                        serOut_ff;
   reg                        nxt_serOut;
   reg                        wrPulse_ff;
   reg                        nxt_wrPulse;
   wire                       sclkS;
   wire                       rstS;
   wire                       loadS;
   wire                       wnrS;
   wire                       sinS;
   wire                       sclkRise;
   wire                       sclkFall;
   wire                       loadRise;
   wire                       defaultLoad;
   wire [`BCSS_DATA_BITS-1:0] rdData;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Two stages per pin; first stage feeds only the second
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         syncA_ff <= 5'h02;
         syncB_ff <= 5'h02;
      end
      else if (clkEn)
      begin
         syncA_ff <= {cfgSerialIn, cfgWriteNotRead, cfgLoadStrobe,
                      cfgDefaultResetN, cfgSerialClock};
         syncB_ff <= syncA_ff;
      end
   end

   assign sclkS = syncB_ff[0];
   assign rstS  = syncB_ff[1];
   assign loadS = syncB_ff[2];
   assign wnrS  = syncB_ff[3];
   assign sinS  = syncB_ff[4];

   // Edge detection on the synchronised link clock and strobe
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sclkDly_ff <= 1'b0;
         loadDly_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         sclkDly_ff <= sclkS;
         loadDly_ff <= loadS;
      end
   end

   assign sclkRise    = sclkS & ~sclkDly_ff;
   assign sclkFall    = ~sclkS & sclkDly_ff;
   assign loadRise    = loadS & ~loadDly_ff;
   assign defaultLoad = ~rstS;

   // ---------------------------------------------------------------
   // Transaction control
   // ---------------------------------------------------------------
   // Shift in, load decode and read shift out
   always @*
   begin
      nxt_state   = state_ff;
      nxt_bitCnt  = bitCnt_ff;
      nxt_addrSh  = addrSh_ff;
      nxt_dataSh  = dataSh_ff;
      nxt_rdAddr  = rdAddr_ff;
      nxt_outSh   = outSh_ff;
      nxt_outCnt  = outCnt_ff;
      nxt_serOut  = serOut_ff;
      nxt_wrPulse = 1'b0;
      if (defaultLoad)
      begin
         nxt_state  = ST_SHIFT;
         nxt_bitCnt = 6'h00;
         nxt_serOut = 1'b0;
      end
      else if (loadRise)
      begin
         nxt_bitCnt = 6'h00;
         if (wnrS)
         begin
            nxt_state   = ST_SHIFT;
            nxt_serOut  = 1'b0;
            nxt_wrPulse = (bitCnt_ff == `BCSS_FRAME_BITS);
         end
         else if (bitCnt_ff >= `BCSS_ADDR_LAST)
         begin
            nxt_rdAddr = addrSh_ff;
            nxt_outSh  = rdData;
            nxt_serOut = rdData[0];
            nxt_outCnt = 5'h00;
            nxt_state  = ST_READOUT;
         end
      end
      else
      begin
         case (state_ff)
            ST_SHIFT:
            begin
               if (sclkRise && (bitCnt_ff < `BCSS_FRAME_BITS))
               begin
                  if (bitCnt_ff < `BCSS_ADDR_LAST)
                     nxt_addrSh = {addrSh_ff[`BCSS_ADDR_BITS-2:0], sinS};
                  else
                     nxt_dataSh = {dataSh_ff[`BCSS_DATA_BITS-2:0], sinS};
                  nxt_bitCnt = bitCnt_ff + 6'h01;
               end
            end
            ST_READOUT:
            begin
               if (sclkFall)
               begin
                  if (outCnt_ff == `BCSS_OUT_LAST)
                  begin
                     nxt_serOut = 1'b0;
                     nxt_state  = ST_SHIFT;
                  end
                  else
                  begin
                     nxt_outSh  = {1'b0, outSh_ff[`BCSS_DATA_BITS-1:1]};
                     nxt_serOut = outSh_ff[1];
                     nxt_outCnt = outCnt_ff + 5'h01;
                  end
               end
            end
            default:
            begin
               nxt_state  = ST_SHIFT;
               nxt_serOut = 1'b0;
            end
         endcase
      end
   end

   // State registers
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_ff   <= ST_SHIFT;
         bitCnt_ff  <= 6'h00;
         addrSh_ff  <= 12'h000;
         dataSh_ff  <= 32'h00000000;
         rdAddr_ff  <= 12'h000;
         outSh_ff   <= 32'h00000000;
         outCnt_ff  <= 5'h00;
         serOut_ff  <= 1'b0;
         wrPulse_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         state_ff   <= nxt_state;
         bitCnt_ff  <= nxt_bitCnt;
         addrSh_ff  <= nxt_addrSh;
         dataSh_ff  <= nxt_dataSh;
         rdAddr_ff  <= nxt_rdAddr;
         outSh_ff   <= nxt_outSh;
         outCnt_ff  <= nxt_outCnt;
         serOut_ff  <= nxt_serOut;
         wrPulse_ff <= nxt_wrPulse;
      end
   end

   // ---------------------------------------------------------------
   // Register bank
   // ---------------------------------------------------------------
   bcss_reg_bank uBank
   (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .clkEn       (clkEn),
      .defaultLoad (defaultLoad),
      .wrEn        (nxt_wrPulse),
      .wrAddr      (addrSh_ff),
      .wrData      (dataSh_ff),
      .rdAddr      (loadRise ? addrSh_ff : rdAddr_ff),
      .rdData      (rdData),
      .cfgRegs     (cfgRegs)
   );

   // Outputs
   assign cfgSerialOut      = serOut_ff;
   assign softResetRequestN = 1'b1;
   assign cfgWritePulse     = wrPulse_ff;

endmodule // bcss_serial_slave

// >>> tb/bcss_mgmt_model.sv
module bcss_mgmt_model
(
   input  logic clk_sys,
   output logic cfgSerialClock,
   output logic cfgLoadStrobe,
   output logic cfgWriteNotRead,
   output logic cfgSerialIn,
   input  logic cfgSerialOut
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle link, clock standing low
   initial
   begin
      cfgSerialClock = 1'b0;
      cfgLoadStrobe = 1'b0;
      cfgWriteNotRead = 1'b0;
      cfgSerialIn = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Top n bits of f, MSB first, 320 ns per bit, then load
   task automatic send(input logic [43:0] f, input int n, input logic w);
      int i;
      cfgWriteNotRead <= w;
      for (i = 43; i > 43 - n; i--)
      begin
         cfgSerialIn <= f[i];
         tick(4);
         cfgSerialClock <= 1'b1;
         tick(4);
         cfgSerialClock <= 1'b0;
      end
      cfgSerialIn <= ~cfgSerialIn; // Line toggled after last bit
      tick(4);
      cfgLoadStrobe <= 1'b1;
      tick(8);
      cfgLoadStrobe <= 1'b0;
      tick(8);
   endtask
   // Read: address frame, then 32 bits sampled before each fall
   task automatic fetch(input logic [11:0] a, output logic [31:0] d);
      int k;
      send({a, 32'h0}, 12, 1'b0);
      for (k = 0; k < 32; k++)
      begin
         cfgSerialClock <= 1'b1;
         tick(4);
         d[k] = cfgSerialOut;
         cfgSerialClock <= 1'b0;
         tick(4);
      end
   endtask
endmodule // bcss_mgmt_model

// >>> tb/bcss_serial_slave_test.sv
`include "bcss_regs.vh"

module bcss_serial_slave_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                                       clk_sys;
   logic                                       rst;
   logic                                       clkEn;
   logic                                       dfltN;
   wire                                        sck;
   wire                                        ld;
   wire                                        wnr;
   wire                                        sdi;
   wire                                        sdo;
   wire                                        rrq;
   wire                                        wp;
   wire  [`BCSS_REG_COUNT*`BCSS_DATA_BITS-1:0] regs;
   logic [31:0]                                exp [16];
   logic [31:0]                                rd;
   int                                         num_errors;
   int                                         total_checks;
   int                                         pulses;
   int                                         cycles;
   bcss_serial_slave i_dut
   (
      .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .cfgSerialClock(sck),
      .cfgDefaultResetN(dfltN), .cfgLoadStrobe(ld), .cfgWriteNotRead(wnr),
      .cfgSerialIn(sdi), .cfgSerialOut(sdo), .softResetRequestN(rrq),
      .cfgWritePulse(wp), .cfgRegs(regs)
   );
   bcss_mgmt_model i_ctrl
   (
      .clk_sys(clk_sys), .cfgSerialClock(sck), .cfgLoadStrobe(ld),
      .cfgWriteNotRead(wnr), .cfgSerialIn(sdi), .cfgSerialOut(sdo)
   );
   always #20 clk_sys = ~clk_sys;
   // Write pulse count and cycle ceiling
   always @(posedge clk_sys)
   begin
      cycles++;
      if (wp === 1'b1)
         pulses++;
      if (cycles == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] want, input string m);
      total_checks++;
      if (got !== want)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask
   task automatic chk_regs;
      int i;
      for (i = 0; i < 16; i++)
         check(regs[32*i +: 32], exp[i], "register content");
   endtask
   // Outputs and bank right after reset
   task automatic t_reset;
      int i;
      for (i = 0; i < 16; i++)
         exp[i] = 32'h0;
      check(rrq, 1'b1, "reset request");
      check(sdo, 1'b0, "idle output");
      chk_regs();
   endtask
   // Full frames to first, middle and last register
   task automatic t_write;
      logic [11:0] a [3] = '{12'h000, 12'h005, 12'h00f};
      logic [31:0] d [3] = '{32'h80000001, 32'ha5c30f96, 32'h7ffffffe};
      int          i;
      pulses = 0;
      for (i = 0; i < 3; i++)
      begin
         i_ctrl.send({a[i], d[i]}, 44, 1'b1);
         exp[a[i]] = d[i];
         check(pulses, i + 1, "write pulse");
      end
      chk_regs();
   endtask
   // Read back, including a never written register
   task automatic t_read;
      logic [11:0] a [4] = '{12'h000, 12'h005, 12'h00f, 12'h007};
      int          i;
      for (i = 0; i < 4; i++)
      begin
         i_ctrl.fetch(a[i], rd);
         @(posedge clk_sys);
         check(rd, exp[a[i]], "read data");
         check(sdo, 1'b0, "output after read");
      end
   endtask
   // Short frame, unmapped address, frozen block
   task automatic t_refuse;
      pulses = 0;
      i_ctrl.send({12'h003, 32'h12345678}, 43, 1'b1);
      check(pulses, 0, "short frame pulse");
      i_ctrl.send({12'h010, 32'h0badf00d}, 44, 1'b1);
      check(pulses, 1, "unmapped frame pulse");
      i_ctrl.fetch(12'h010, rd);
      check(rd, 32'h0, "unmapped read");
      clkEn <= 1'b0;
      i_ctrl.send({12'h003, 32'h12345678}, 44, 1'b1);
      clkEn <= 1'b1;
      check(pulses, 1, "refused writes");
      chk_regs();
   endtask
   // Config reset clears the bank, writes work after it
   task automatic t_default;
      int i;
      dfltN <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (i = 0; i < 16; i++)
         exp[i] = 32'h0;
      chk_regs();
      dfltN <= 1'b1;
      repeat (4) @(posedge clk_sys);
      i_ctrl.send({12'h009, 32'hc0ffee11}, 44, 1'b1);
      exp[9] = 32'hc0ffee11;
      chk_regs();
   endtask
   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      clkEn = 1'b1;
      dfltN = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_write();
      t_read();
      t_refuse();
      t_default();
      complete_run();
   end
endmodule // bcss_serial_slave_test

// >>> tb/bcss_slave_chk.sv
`include "bcss_regs.vh"

module bcss_slave_chk
(
   input logic                                       clk_sys,
   input logic                                       rst,
   input logic                                       cfgSerialClock,
   input logic                                       cfgDefaultResetN,
   input logic                                       cfgLoadStrobe,
   input logic                                       cfgWriteNotRead,
   input logic                                       cfgSerialOut,
   input logic                                       softResetRequestN,
   input logic                                       cfgWritePulse,
   input logic [`BCSS_REG_COUNT*`BCSS_DATA_BITS-1:0] cfgRegs
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Config reset held, and config reset long released
   sequence s_dflt;
      !cfgDefaultResetN [*5];
   endsequence
   sequence s_quiet;
      cfgDefaultResetN [*5];
   endsequence
   property p_req_high;
      softResetRequestN;
   endproperty
   property p_rel_low;
      $fell(rst) |-> !cfgSerialOut && !cfgWritePulse;
   endproperty
   property p_dflt_regs;
      s_dflt |-> cfgRegs == '0;
   endproperty
   property p_dflt_out;
      s_dflt |-> !cfgSerialOut;
   endproperty
   property p_pulse_one;
      cfgWritePulse |=> !cfgWritePulse;
   endproperty
   property p_pulse_cause;
      cfgWritePulse |-> $past(cfgLoadStrobe, 3) && $past(cfgWriteNotRead, 3);
   endproperty
   property p_regs_pulse;
      s_quiet ##0 $changed(cfgRegs) |-> cfgWritePulse;
   endproperty
   property p_out_fall;
      $changed(cfgSerialOut) |-> !$past(cfgSerialClock, 2);
   endproperty
   property p_out_hold;
      $rose(cfgSerialClock) |=> $stable(cfgSerialOut) [*3];
   endproperty
   a_req_high: assert property (p_req_high) else $error("request not high");
   a_rel_low: assert property (p_rel_low) else $error("outputs busy at release");
   a_dflt_regs: assert property (p_dflt_regs) else $error("defaults not loaded");
   a_dflt_out: assert property (p_dflt_out) else $error("output busy in reset");
   a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse no load");
   a_regs_pulse: assert property (p_regs_pulse) else $error("silent change");
   a_out_fall: assert property (p_out_fall) else $error("output moved early");
   a_out_hold: assert property (p_out_hold) else $error("output not held");
endmodule // bcss_slave_chk

bind bcss_serial_slave bcss_slave_chk i_chk
(
   .clk_sys          (clk_sys),
   .rst              (rst),
   .cfgSerialClock   (cfgSerialClock),
   .cfgDefaultResetN (cfgDefaultResetN),
   .cfgLoadStrobe    (cfgLoadStrobe),
   .cfgWriteNotRead  (cfgWriteNotRead),
   .cfgSerialOut     (cfgSerialOut),
   .softResetRequestN(softResetRequestN),
   .cfgWritePulse    (cfgWritePulse),
   .cfgRegs          (cfgRegs)
);
